// ===== atw_trap_unit.sv
// address trap and watchdog overflow handling with apb register access
`timescale 1ns/1ns
`include "atw_consts.svh"

module atw_trap_unit
	import atw_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire atw_fetch_t fetch,
	input wire logic wdOverflow,
	input wire logic lowSpeedMode,
	output logic trapInterruptRequest,
	output logic watchdogInterruptRequest,
	output logic internalResetRequest,
	output logic watchdogCounterClear,
	output logic watchdogEnable,
	output logic [1:0] watchdogPeriod,
	output logic fastOscRestart
);

	// 24 fast periods come to 150 system cycles; counter sized to hold that
	localparam logic [7:0] RST_CYC = 8'(`ATW_RST_CYC);
	localparam int RST_LEN = `ATW_RST_CYC;

	function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		inRange = (a >= lo) && (a <= hi);
	endfunction : inRange

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire logic access = psel && penable;
	wire logic hitSetup = paddr == `ATW_ADDR_SETUP;
	wire logic hitCmd = paddr == `ATW_ADDR_CMD;
	wire logic hitStatus = paddr == `ATW_ADDR_STATUS;
	wire logic mapped = hitSetup || hitCmd || hitStatus;
	wire logic wrSetup = access && pwrite && hitSetup;
	wire logic wrCmd = access && pwrite && hitCmd;
	wire logic [7:0] cmdByte = pwdata[7:0];
	wire logic cmdApply = wrCmd && (cmdByte == `ATW_CMD_APPLY);
	wire logic cmdClear = wrCmd && (cmdByte == `ATW_CMD_CLEAR);
	wire logic cmdDisable = wrCmd && (cmdByte == `ATW_CMD_DISABLE);

	atw_setup_t setup_q, setup_d;
	logic ramShadow_q;
	logic wdEnable_q;
	atw_state_t state_q;
	logic [7:0] rstCnt_q;

	// ----------------------------------------------------------------
	// setup register
	// ----------------------------------------------------------------
	// output select can only be cleared once set; disable only via b1 code
	always_comb begin
		setup_d = setup_q;
		if (wrSetup) begin
			setup_d.ramSel = pwdata[`ATW_BIT_RAMSEL];
			setup_d.trapAction = pwdata[`ATW_BIT_TRAPACT];
			setup_d.wdEnable = pwdata[`ATW_BIT_WDEN];
			setup_d.wdPeriod = pwdata[`ATW_BIT_WDTT_LO +: 2];
			setup_d.wdOutSel = setup_q.wdOutSel & pwdata[`ATW_BIT_WDOUT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			setup_q <= atw_setup_t'(6'(`ATW_SETUP_RESET));
		end else begin
			setup_q <= setup_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ramShadow_q <= 1'b1;
		end else if (cmdApply) begin
			ramShadow_q <= setup_q.ramSel;
		end
	end

	wire logic wdEnable_d = setup_q.wdEnable ? 1'b1 :
		(cmdDisable ? 1'b0 : wdEnable_q);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wdEnable_q <= 1'b1;
		end else begin
			wdEnable_q <= wdEnable_d;
		end
	end

	// ----------------------------------------------------------------
	// fetch compare
	// ----------------------------------------------------------------
	wire logic fetchSys = fetch.valid && (inRange(fetch.addr, `ATW_SPECIAL_LO, `ATW_SPECIAL_HI)
		|| inRange(fetch.addr, `ATW_DEBUG_LO, `ATW_DEBUG_HI));
	wire logic fetchRam = fetch.valid && ramShadow_q
		&& inRange(fetch.addr, `ATW_RAM_LO, `ATW_RAM_HI);
	wire logic trapHit = fetchSys || fetchRam;
	wire logic trapIrq = trapHit && !setup_q.trapAction;
	wire logic trapRst = trapHit && setup_q.trapAction;
	wire logic wdEvent = wdOverflow && wdEnable_q;
	wire logic wdRst = wdEvent && setup_q.wdOutSel;
	wire logic wdIrq = wdEvent && !setup_q.wdOutSel;
	wire logic rstStart = (state_q == ATW_RUN) && (trapRst || wdRst);

	// ----------------------------------------------------------------
	// reset pulse sequencer
	// ----------------------------------------------------------------
	// pulse is timed on sys_clk; in slow mode the fast oscillator is restarted
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= ATW_RUN;
			rstCnt_q <= 8'h00;
		end else begin
			unique case (state_q)
				ATW_RUN: begin
					if (trapRst || wdRst) begin
						state_q <= ATW_RESET;
						rstCnt_q <= RST_CYC - 8'h01;
					end
				end
				ATW_RESET: begin
					if (rstCnt_q == 8'h00) begin
						state_q <= ATW_RUN;
					end else begin
						rstCnt_q <= rstCnt_q - 8'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trapInterruptRequest <= 1'b0;
			watchdogInterruptRequest <= 1'b0;
			internalResetRequest <= 1'b0;
			watchdogCounterClear <= 1'b0;
			watchdogEnable <= 1'b1;
			watchdogPeriod <= 2'h0;
			fastOscRestart <= 1'b0;
		end else begin
			trapInterruptRequest <= trapIrq && (state_q == ATW_RUN);
			watchdogInterruptRequest <= wdIrq && (state_q == ATW_RUN);
			internalResetRequest <= rstStart || ((state_q == ATW_RESET) && (rstCnt_q != 8'h00));
			watchdogCounterClear <= cmdClear || !wdEnable_q;
			watchdogEnable <= wdEnable_q;
			watchdogPeriod <= setup_q.wdPeriod;
			fastOscRestart <= rstStart && lowSpeedMode;
		end
	end

	// setup and command read as zero; status shows applied trap state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && hitStatus) ?
				{28'h0000000, state_q == ATW_RESET, wdEnable_q, ramShadow_q, setup_q.trapAction}
				: 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_sys_trap;
		@(posedge sys_clk) disable iff (srst)
		(fetchSys && !setup_q.trapAction && state_q == ATW_RUN) |=> trapInterruptRequest;
	endproperty
	a_sys_trap: assert property (p_sys_trap) else $error("system area fetch no trap irq");

	property p_ram_gate;
		@(posedge sys_clk) disable iff (srst)
		(fetch.valid && !fetchSys && !ramShadow_q) |=> !trapInterruptRequest && !$rose(internalResetRequest);
	endproperty
	a_ram_gate: assert property (p_ram_gate) else $error("ram fetch trapped while off");

	property p_apply;
		@(posedge sys_clk) disable iff (srst)
		!cmdApply |=> $stable(ramShadow_q);
	endproperty
	a_apply: assert property (p_apply) else $error("shadow moved without d2");

	property p_apply_load;
		@(posedge sys_clk) disable iff (srst)
		cmdApply |=> ramShadow_q == $past(setup_q.ramSel);
	endproperty
	a_apply_load: assert property (p_apply_load) else $error("d2 did not load shadow");

	property p_trap_rst;
		@(posedge sys_clk) disable iff (srst)
		(trapRst && state_q == ATW_RUN) |=> internalResetRequest && !trapInterruptRequest;
	endproperty
	a_trap_rst: assert property (p_trap_rst) else $error("trap reset missing");

	property p_wd_rst;
		@(posedge sys_clk) disable iff (srst)
		(wdRst && state_q == ATW_RUN) |=> internalResetRequest [*8];
	endproperty
	a_wd_rst: assert property (p_wd_rst) else $error("watchdog reset too short");

	property p_rst_len;
		@(posedge sys_clk) disable iff (srst)
		$rose(internalResetRequest) |-> ##[1:RST_LEN] !internalResetRequest;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse too long");

	property p_wd_irq;
		@(posedge sys_clk) disable iff (srst)
		(wdIrq && state_q == ATW_RUN) |=> watchdogInterruptRequest && !internalResetRequest;
	endproperty
	a_wd_irq: assert property (p_wd_irq) else $error("watchdog irq missing");

	property p_slow;
		@(posedge sys_clk) disable iff (srst)
		fastOscRestart |-> internalResetRequest;
	endproperty
	a_slow: assert property (p_slow) else $error("osc restart without reset");

	property p_clear;
		@(posedge sys_clk) disable iff (srst)
		cmdClear |=> watchdogCounterClear;
	endproperty
	a_clear: assert property (p_clear) else $error("clear code lost");

	c_trap_irq: cover property (@(posedge sys_clk) disable iff (srst) trapInterruptRequest);
	c_trap_rst: cover property (@(posedge sys_clk) disable iff (srst) trapRst ##1 internalResetRequest);
	c_wd_rst: cover property (@(posedge sys_clk) disable iff (srst) wdRst);
	c_apply: cover property (@(posedge sys_clk) disable iff (srst) cmdApply ##1 !ramShadow_q);

endmodule : atw_trap_unit

// ===== atw_consts.svh
// offsets, fields, reset values and timing counts of the address trap and watchdog reset block
`ifndef ATW_CONSTS_SVH
`define ATW_CONSTS_SVH

// ----------------------------------------------------------------
// register indices 34h, 35h, 36h; byte address is four times the index
// ----------------------------------------------------------------
`define ATW_IDX_SETUP 8'h34
`define ATW_IDX_CMD 8'h35
`define ATW_IDX_STATUS 8'h36
`define ATW_ADDR_SETUP 12'h0d0
`define ATW_ADDR_CMD 12'h0d4
`define ATW_ADDR_STATUS 12'h0d8

// ----------------------------------------------------------------
// setup register fields
// ----------------------------------------------------------------
`define ATW_BIT_WDOUT 0
`define ATW_BIT_WDTT_LO 1
`define ATW_BIT_WDEN 3
`define ATW_BIT_TRAPACT 4
`define ATW_BIT_RAMSEL 5
`define ATW_SETUP_RESET 8'h39

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define ATW_CMD_APPLY 8'hd2
`define ATW_CMD_CLEAR 8'h4e
`define ATW_CMD_DISABLE 8'hb1

// ----------------------------------------------------------------
// address map seen by fetch compare
// ----------------------------------------------------------------
`define ATW_SPECIAL_LO 16'h0000
`define ATW_SPECIAL_HI 16'h003f
`define ATW_RAM_LO 16'h0040
`define ATW_RAM_HI 16'h083f
`define ATW_DEBUG_LO 16'h0f80
`define ATW_DEBUG_HI 16'h0fff

// ----------------------------------------------------------------
// reset pulse timing: 24 high-frequency periods, fc 16 MHz = 62.5 ns
// ----------------------------------------------------------------
`define ATW_FC_PERIODS 24
`define ATW_FC_PS 62500
`define ATW_SYS_PS 10000
`define ATW_RST_CYC ((`ATW_FC_PERIODS * `ATW_FC_PS) / `ATW_SYS_PS)

`endif

// ===== atw_pkg.sv
// types of the address trap and watchdog reset block
package atw_pkg;

	typedef struct packed {
		logic ramSel;
		logic trapAction;
		logic wdEnable;
		logic [1:0] wdPeriod;
		logic wdOutSel;
	} atw_setup_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} atw_fetch_t;

	typedef enum logic [1:0] {
		ATW_RUN = 2'b01,
		ATW_RESET = 2'b10
	} atw_state_t;

endpackage : atw_pkg

// ===== atw_cpu_model.sv
// core fetch model driving the trap unit fetch port
`timescale 1ns/1ns
module atw_cpu_model
	import atw_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic internalResetRequest,
	input wire logic reqGo,
	input wire logic reqFetch,
	input wire logic [15:0] reqAddr,
	output atw_fetch_t fetch
);
	// stack pointer is set before any trap is armed
	// each trap is returned from before the next
	always_ff @(posedge sys_clk) begin
		if (srst || internalResetRequest) begin
			fetch.valid <= 1'b0;
			fetch.addr <= ~fetch.addr;
		end else if (reqGo) begin
			fetch.valid <= reqFetch;
			fetch.addr <= reqAddr;
		end else begin
			// idle bus never repeats the last address
			fetch.valid <= 1'b0;
			fetch.addr <= ~fetch.addr;
		end
	end
endmodule : atw_cpu_model

// ===== address_trap_and_wdt_reset_tb.sv
// bench for the address trap and watchdog reset block
`timescale 1ns/1ns
`include "atw_consts.svh"
module address_trap_and_wdt_reset_tb
	import atw_pkg::*;
;
	logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, er, wdOverflow = 0, lowSpeedMode = 0;
	logic tIrq, wIrq, rReq, clr, wEn, osc, go = 0, reqF = 0;
	logic [1:0] per;
	logic [15:0] reqA = 0;
	logic [15:0] tbl [8] = '{16'h0010, 16'h003f, 16'h0040, 16'h0500, 16'h083f,
		16'h0840, 16'h0f80, 16'h0fff};
	atw_fetch_t fetch;
	int errors = 0, num_checks = 0, cyc = 0, seed = 32'h0388;
	int act = 1, ramAp = 1, ramWr = 1, sEn = 1, wdEn = 1;
	int nIrq = 0, nWd = 0, nRst = 0, nOsc = 0, nClr = 0;
	int eIrq = 0, eWd = 0, eRst = 0, eOsc = 0, eClr = 0;

	atw_trap_unit DUT (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .fetch, .wdOverflow, .lowSpeedMode,
		.trapInterruptRequest(tIrq), .watchdogInterruptRequest(wIrq),
		.internalResetRequest(rReq), .watchdogCounterClear(clr),
		.watchdogEnable(wEn), .watchdogPeriod(per), .fastOscRestart(osc));
	atw_cpu_model cpu (.sys_clk, .srst, .internalResetRequest(rReq), .reqGo(go),
		.reqFetch(reqF), .reqAddr(reqA), .fetch);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		nIrq += (tIrq === 1'b1);
		nWd += (wIrq === 1'b1);
		nRst += (rReq === 1'b1);
		nOsc += (osc === 1'b1);
		nClr += (clr === 1'b1);
		if (++cyc > 20000) begin
			errors++;
			summarize();
		end
	end

	task summarize();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk) penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask : apb

	// ------------------------------------------------
	// register writes mirrored into the model
	// ------------------------------------------------
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1, a, d);
		if (a == `ATW_ADDR_SETUP) {ramWr, act, sEn} = {32'(d[5]), 32'(d[4]), 32'(d[3])};
		if (a == `ATW_ADDR_CMD && d == `ATW_CMD_APPLY) ramAp = ramWr;
		if (a == `ATW_ADDR_CMD && d == `ATW_CMD_CLEAR) eClr++;
		if (a == `ATW_ADDR_CMD && d == `ATW_CMD_DISABLE && !sEn) wdEn = 0;
	endtask : wr

	task st();
		apb(0, `ATW_ADDR_STATUS, 0);
		chk(rd, act + 2 * ramAp + 4 * wdEn);
	endtask : st

	task fx(input logic [15:0] a, input logic f);
		logic t;
		t = f && (a <= `ATW_SPECIAL_HI || (a >= `ATW_DEBUG_LO && a <= `ATW_DEBUG_HI)
			|| (ramAp != 0 && a >= `ATW_RAM_LO && a <= `ATW_RAM_HI));
		reqA <= a;
		reqF <= f;
		go <= 1;
		@(posedge sys_clk) go <= 0;
		repeat (t && act ? `ATW_RST_CYC + 10 : 4) @(posedge sys_clk);
		if (t && act) {eRst, eOsc} = {eRst + `ATW_RST_CYC, eOsc + 32'(lowSpeedMode)};
		else if (t) eIrq++;
		chk(nIrq, eIrq);
		chk(nRst, eRst);
		chk(nOsc, eOsc);
	endtask : fx

	task sweep();
		foreach (tbl[i]) fx(tbl[i], 1'b1);
		repeat (3) fx({4'h0, 12'($random(seed))}, 1'($random(seed)));
		fx(16'h0f90, 1'b0);
	endtask : sweep

	task ov();
		wdOverflow <= 1;
		@(posedge sys_clk) wdOverflow <= 0;
		repeat (`ATW_RST_CYC + 10) @(posedge sys_clk);
	endtask : ov

	initial begin
		repeat (12) @(posedge sys_clk);
		srst <= 0;
		@(posedge sys_clk);
		st();
		apb(0, `ATW_ADDR_SETUP, 0);
		chk(rd, 0);
		apb(1, {2'b11, 10'($random(seed))}, 8'hd2);
		chk(er, 1);
		wr(`ATW_ADDR_SETUP, 8'h0f);
		// period output is registered one edge after the setup write lands
		@(posedge sys_clk);
		chk(per, 3);
		st();
		sweep();
		wr(`ATW_ADDR_CMD, `ATW_CMD_APPLY);
		st();
		sweep();
		wr(`ATW_ADDR_SETUP, 8'h2f);
		sweep();
		wr(`ATW_ADDR_CMD, `ATW_CMD_APPLY);
		sweep();
		wr(`ATW_ADDR_CMD, `ATW_CMD_CLEAR);
		wr(`ATW_ADDR_CMD, 8'h00);
		repeat (3) @(posedge sys_clk);
		chk(nClr, eClr);
		lowSpeedMode <= 1;
		ov();
		chk(nRst, eRst + `ATW_RST_CYC);
		chk(nOsc, eOsc + 1);
		{eRst, eOsc} = {eRst + `ATW_RST_CYC, eOsc + 1};
		wr(`ATW_ADDR_SETUP, 8'h38);
		ov();
		chk(nWd, eWd + 1);
		eWd++;
		lowSpeedMode <= 1'($random(seed));
		fx(16'h0f90, 1'b1);
		fx(16'h0100, 1'b1);
		wr(`ATW_ADDR_SETUP, 8'h30);
		wr(`ATW_ADDR_CMD, `ATW_CMD_DISABLE);
		repeat (3) @(posedge sys_clk);
		chk(wEn, 0);
		chk(clr, 1);
		ov();
		chk(nRst + nWd, eRst + eWd);
		summarize();
	end
endmodule : address_trap_and_wdt_reset_tb
